// ==== hw/i2csc_consts.vh ====
`ifndef I2CSC_CONSTS_VH
`define I2CSC_CONSTS_VH
// Register byte offsets
`define I2CSC_OFS_STATUS2 8'h18
`define I2CSC_OFS_CLKCFG 8'h1C
`define I2CSC_OFS_CTRL 8'h00
`define I2CSC_OFS_ADDR 8'h04
`define I2CSC_OFS_PEC 8'h08
// Reset values
`define I2CSC_RST_STATUS2 16'h0002
`define I2CSC_RST_CLKCFG 16'h0000
// Clock config fields
`define I2CSC_CLK_FAST 15
`define I2CSC_CLK_DUTY 14
`define I2CSC_CLK_MASK 16'hCFFF
// Control register fields
`define I2CSC_CTL_EN 0
`define I2CSC_CTL_PEC_ENABLE 1
`define I2CSC_CTL_SMBHOST 2
`define I2CSC_CTL_ARP_ENABLE 3
`define I2CSC_CTL_GENERAL_CALL_ENABLE 4
`define I2CSC_CTL_MASK 16'h001F
// Reserved-address codes (7-bit)
`define I2CSC_ADR_GCALL 7'h00
`define I2CSC_ADR_SMBDEF 7'h61
`define I2CSC_ADR_SMBHOST 7'h08
// Duty multipliers
`define I2CSC_MUL_LOW_2 5'h02
`define I2CSC_MUL_LOW_16 5'h10
`define I2CSC_MUL_HIGH_9 5'h09
`define I2CSC_MUL_ONE 5'h01
`endif

// ==== hw/i2csc_scl_gen.v ====
`timescale 1ns/10ps
`include "i2csc_consts.vh"
// *****************************
// SCL phase generator
// *****************************
module i2csc_scl_gen #(
  parameter DIV_W = 12
) (
  // Clock and reset
  input wire clk_sys,
  input wire reset_n,
  // Control
  input wire run,
  input wire fast,
  input wire duty,
  input wire [DIV_W-1:0] divider,
  // Output
  output reg scl_level,
  output reg scl_edge
);
  reg [DIV_W+4:0] cnt;
  reg [4:0] mul_low;
  reg [4:0] mul_high;
  wire [DIV_W+4:0] reload;

  // Multipliers per duty choice
  always @* begin
    if (!fast) begin
      mul_low = `I2CSC_MUL_ONE;
      mul_high = `I2CSC_MUL_ONE;
    end else if (!duty) begin
      mul_low = `I2CSC_MUL_LOW_2;
      mul_high = `I2CSC_MUL_ONE;
    end else begin
      mul_low = `I2CSC_MUL_LOW_16;
      mul_high = `I2CSC_MUL_HIGH_9;
    end
  end

  // Next phase length: scl high now means low phase next
  assign reload = (scl_level ? mul_low : mul_high) * divider;

  // Phase counter reloaded at every edge
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      cnt <= {(DIV_W+5){1'b0}};
      scl_level <= 1'b1;
      scl_edge <= 1'b0;
    end else begin
      scl_edge <= 1'b0;
      if (!run) begin
        cnt <= {(DIV_W+5){1'b0}};
        scl_level <= 1'b1;
      end else if (cnt <= {{(DIV_W+4){1'b0}}, 1'b1}) begin
        cnt <= reload;
        scl_level <= ~scl_level;
        scl_edge <= 1'b1;
      end else begin
        cnt <= cnt - {{(DIV_W+4){1'b0}}, 1'b1};
      end
    end
  end
endmodule

// ==== hw/i2csc_status_clk.v ====
// Functional notes
// - PEC byte shown in status bits 15:8 when PEC enabled, else zero
// - Bit 7: zero for address one, one for two
// - Bit 6 set on host header when enabled
// - Bit 5 set on default address with ARP
// - Bit 4 set on general call when enabled
// - Address flags cleared on stop, restart, disable
// - Bit 2 follows R/W after address phase as slave, inverted R/W as master
// - Direction cleared on stop, restart, arblost, disable
// - Busy set on SDA/SCL low, cleared on stop
// - Busy tracked even when disabled
// - Bit 0 set after start sent as master
// - Master cleared on stop, arblost, disable
// - Bit 15 picks standard or fast mode
// - Bit 14 picks ratio 2 or 16/9
// - Divider bits 11:0 in clock periods
// - Equal duty: low and high one divider
// - Ratio two: low twice, high once
// - Ratio 16/9: low sixteen, high nine
// - Start-sent flag raised after master start
`timescale 1ns/10ps
`include "i2csc_consts.vh"
module i2csc_status_clk #(
  parameter DIV_W = 12
) (
  // Clock and reset
  input wire clk_sys,
  input wire reset_n,
  // Avalon-MM slave
  input wire [7:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0] avs_byteenable,
  output reg [31:0] avs_readdata,
  output wire avs_waitrequest,
  // Bus pins (inputs from pads)
  input wire sda_in,
  input wire scl_in,
  // Protocol events from the byte engine
  input wire start_req,
  input wire addr_done,
  input wire [6:0] addr_rx,
  input wire addr_rw,
  input wire slave_addressed,
  input wire arb_lost,
  input wire restart_seen,
  input wire stop_seen,
  // SCL drive
  output wire scl_out,
  output wire scl_oe,
  output wire start_sent_flag
);
  // *****************************
  // Registers
  // *****************************
  reg [15:0] ctrl;
  reg [15:0] addr_cfg;
  reg [7:0] pec_value;
  reg [15:0] clk_cfg;
  reg second_addr_match;
  reg smb_host_hdr_seen;
  reg smb_default_addr_seen;
  reg general_call_seen;
  reg transmit_direction;
  reg bus_busy;
  reg master_active;
  reg start_flag;
  reg rd_ack;
  reg [1:0] sda_sync;
  reg [1:0] scl_sync;
  wire en;
  wire scl_level;
  reg [31:0] next_readdata;
  wire [15:0] next_ctrl;
  wire [15:0] next_addr_cfg;
  wire [15:0] next_clk_cfg;
  wire hit_one;
  wire hit_two;
  wire hit_gcall;
  wire hit_smb_default;
  wire hit_smb_host;
  wire set_addr_flags;
  wire clear_master;
  wire start_go;
  wire [6:0] own_address_one;
  wire [6:0] own_address_two;
  wire [15:0] status2;
  wire [15:0] wmask;
  wire wr_ctrl;
  wire wr_addr;
  wire wr_clk;
  wire wr_pec;
  wire clear_addr;

  assign en = ctrl[`I2CSC_CTL_EN];
  assign own_address_one = addr_cfg[6:0];
  assign own_address_two = addr_cfg[14:8];
  assign start_sent_flag = start_flag;

  // *****************************
  // Avalon slave
  // *****************************
  // Writes complete at once, reads take one wait cycle
  assign avs_waitrequest = avs_read & ~rd_ack;
  assign wmask = {{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
  assign wr_ctrl = avs_write && (avs_address == `I2CSC_OFS_CTRL);
  assign wr_addr = avs_write && (avs_address == `I2CSC_OFS_ADDR);
  assign wr_pec = avs_write && (avs_address == `I2CSC_OFS_PEC);
  // Clock config write ignored while enabled
  assign wr_clk = avs_write && (avs_address == `I2CSC_OFS_CLKCFG) && !en;

  // Status register image
  assign status2 = {(ctrl[`I2CSC_CTL_PEC_ENABLE] ? pec_value : 8'h00),
                    second_addr_match, smb_host_hdr_seen, smb_default_addr_seen,
                    general_call_seen, 1'b0, transmit_direction, bus_busy, master_active};

  // Read decode, unmapped reads as zero
  always @* begin
    next_readdata = 32'h00000000;
    case (avs_address)
      `I2CSC_OFS_STATUS2: next_readdata = {16'h0000, status2};
      `I2CSC_OFS_CLKCFG: next_readdata = {16'h0000, clk_cfg};
      `I2CSC_OFS_CTRL: next_readdata = {16'h0000, ctrl};
      `I2CSC_OFS_ADDR: next_readdata = {16'h0000, addr_cfg};
      `I2CSC_OFS_PEC: next_readdata = {24'h000000, pec_value};
      default: next_readdata = 32'h00000000;
    endcase
  end

  // Read data register: loaded once per read, held until the next one
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      rd_ack <= 1'b0;
      avs_readdata <= 32'h00000000;
    end else begin
      // Acknowledge lasts one cycle, so a read held past its answer starts a new access
      rd_ack <= avs_read & ~rd_ack;
      if (avs_read && !rd_ack) begin
        avs_readdata <= next_readdata;
      end
    end
  end

  // Byte-lane merge of write data; reserved bits always stay zero
  assign next_ctrl = ((ctrl & ~wmask) | (avs_writedata[15:0] & wmask)) & `I2CSC_CTL_MASK;
  assign next_addr_cfg = ((addr_cfg & ~wmask) | (avs_writedata[15:0] & wmask)) & 16'h7F7F;
  assign next_clk_cfg = ((clk_cfg & ~wmask) | (avs_writedata[15:0] & wmask)) & `I2CSC_CLK_MASK;

  // Control register
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      ctrl <= 16'h0000;
    end else if (wr_ctrl) begin
      ctrl <= next_ctrl;
    end
  end

  // Own addresses one and two
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      addr_cfg <= 16'h0000;
    end else if (wr_addr) begin
      addr_cfg <= next_addr_cfg;
    end
  end

  // PEC source byte, low lane only
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      pec_value <= 8'h00;
    end else if (wr_pec && avs_byteenable[0]) begin
      pec_value <= avs_writedata[7:0];
    end
  end

  // Clock config; the strobe already drops writes while enabled
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      clk_cfg <= `I2CSC_RST_CLKCFG;
    end else if (wr_clk) begin
      clk_cfg <= next_clk_cfg;
    end
  end

  // *****************************
  // Pin synchronisers
  // *****************************
  // SDA synchroniser; only the second stage feeds logic
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      sda_sync <= 2'b11;
    end else begin
      sda_sync <= {sda_sync[0], sda_in};
    end
  end

  // SCL synchroniser; resets to the idle-high line level
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      scl_sync <= 2'b11;
    end else begin
      scl_sync <= {scl_sync[0], scl_in};
    end
  end

  // *****************************
  // Status flags
  // *****************************
  assign clear_addr = stop_seen | restart_seen | !en;

  // Busy runs regardless of enable; stop clears, low line sets
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      bus_busy <= 1'b1;
    end else if (!sda_sync[1] || !scl_sync[1]) begin
      bus_busy <= 1'b1;
    end else if (stop_seen) begin
      bus_busy <= 1'b0;
    end
  end

  // Address decode against own addresses and the reserved SMBus codes
  // Address one wins when both own addresses are equal
  assign hit_one = (addr_rx == own_address_one);
  assign hit_two = (addr_rx == own_address_two) && !hit_one;
  assign hit_gcall = (addr_rx == `I2CSC_ADR_GCALL) && ctrl[`I2CSC_CTL_GENERAL_CALL_ENABLE];
  assign hit_smb_default = (addr_rx == `I2CSC_ADR_SMBDEF) && ctrl[`I2CSC_CTL_ARP_ENABLE];
  assign hit_smb_host = (addr_rx == `I2CSC_ADR_SMBHOST) && ctrl[`I2CSC_CTL_SMBHOST] && ctrl[`I2CSC_CTL_ARP_ENABLE];
  // Flags only follow an address taken as slave
  assign set_addr_flags = addr_done && slave_addressed && !master_active;

  // Second-address match flag
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      second_addr_match <= 1'b0;
    end else if (clear_addr) begin
      second_addr_match <= 1'b0;
    end else if (set_addr_flags) begin
      second_addr_match <= hit_two;
    end
  end

  // SMBus host header flag
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      smb_host_hdr_seen <= 1'b0;
    end else if (clear_addr) begin
      smb_host_hdr_seen <= 1'b0;
    end else if (set_addr_flags) begin
      smb_host_hdr_seen <= hit_smb_host;
    end
  end

  // SMBus default address flag
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      smb_default_addr_seen <= 1'b0;
    end else if (clear_addr) begin
      smb_default_addr_seen <= 1'b0;
    end else if (set_addr_flags) begin
      smb_default_addr_seen <= hit_smb_default;
    end
  end

  // General call flag
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      general_call_seen <= 1'b0;
    end else if (clear_addr) begin
      general_call_seen <= 1'b0;
    end else if (set_addr_flags) begin
      general_call_seen <= hit_gcall;
    end
  end

  // Direction bit
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      transmit_direction <= 1'b0;
    end else if (stop_seen || restart_seen || arb_lost || !en) begin
      transmit_direction <= 1'b0;
    end else if (addr_done) begin
      // Master writes when R/W is 0; slave transmits when R/W is 1
      transmit_direction <= master_active ? ~addr_rw : addr_rw;
    end
  end

  // Master role ends on stop, lost arbitration or disable
  assign clear_master = !en || arb_lost || stop_seen;
  // A start only goes out on an idle bus
  assign start_go = start_req && !bus_busy;

  // Start-sent flag: raised when a start goes out, dropped after the address
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      start_flag <= 1'b0;
    end else if (clear_master) begin
      start_flag <= 1'b0;
    end else if (start_go) begin
      start_flag <= 1'b1;
    end else if (addr_done) begin
      start_flag <= 1'b0;
    end
  end

  // Master role follows the start-sent flag one cycle later
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      master_active <= 1'b0;
    end else if (clear_master) begin
      master_active <= 1'b0;
    end else if (start_flag) begin
      master_active <= 1'b1;
    end
  end

  // *****************************
  // SCL generation
  // *****************************
  i2csc_scl_gen #(
    .DIV_W(DIV_W)
  ) u_scl (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .run(en && master_active),
    .fast(clk_cfg[`I2CSC_CLK_FAST]),
    .duty(clk_cfg[`I2CSC_CLK_DUTY]),
    .divider(clk_cfg[DIV_W-1:0]),
    .scl_level(scl_level),
    .scl_edge()
  );

  // Open drain: drive only the low phase
  assign scl_out = 1'b0;
  assign scl_oe = en && master_active && !scl_level;
endmodule

// ==== test/i2csc_bus_model.sv ====
`timescale 1ns/10ps
// ****
// Far-side bus model
// ****
module i2csc_bus_model (
  // Device drive
  input wire scl_oe,
  // Far-side holds
  input wire pull_sda,
  input wire pull_scl,
  // Line levels
  output wire sda_in,
  output wire scl_in
);
  // Pull-ups keep released lines high; any pull wins
  assign sda_in = ~pull_sda;
  assign scl_in = ~(scl_oe | pull_scl);
endmodule

// ==== test/i2csc_port_checker.sv ====
`timescale 1ns/10ps
// ****
// Port checker
// ****
module i2csc_port_checker #(
  parameter DIV_W = 12
) (
  // Clock and reset
  input wire clk_sys,
  input wire reset_n,
  // Register bus
  input wire [7:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0] avs_byteenable,
  input wire [31:0] avs_readdata,
  input wire avs_waitrequest,
  // Pins and events
  input wire sda_in,
  input wire scl_in,
  input wire start_req,
  input wire addr_done,
  input wire [6:0] addr_rx,
  input wire addr_rw,
  input wire slave_addressed,
  input wire arb_lost,
  input wire restart_seen,
  input wire stop_seen,
  // SCL drive
  input wire scl_out,
  input wire scl_oe,
  input wire start_sent_flag
);
  reg en, fast, duty, prev;
  reg [11:0] div;
  reg [15:0] cnt;
  reg [1:0] nph;
  wire [15:0] lo = {4'h0, div} * (fast ? (duty ? 16'h0010 : 16'h0002) : 16'h0001);
  wire [15:0] hi = {4'h0, div} * ((fast && duty) ? 16'h0009 : 16'h0001);
  wire mapped = avs_address == 8'h00 || avs_address == 8'h04 || avs_address == 8'h08
    || avs_address == 8'h18 || avs_address == 8'h1C;
  // Shadow of config and length of the current SCL phase
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      en <= 1'b0;
      fast <= 1'b0;
      duty <= 1'b0;
      div <= 12'h000;
      prev <= 1'b0;
      cnt <= 16'h0000;
      nph <= 2'h0;
    end else begin
      if (avs_write && avs_address == 8'h00) en <= avs_writedata[0];
      if (avs_write && avs_address == 8'h1C && !en) begin
        fast <= avs_writedata[15];
        duty <= avs_writedata[14];
        div <= avs_writedata[11:0];
      end
      prev <= scl_oe;
      cnt <= (scl_oe != prev) ? 16'h0001 : cnt + 16'h0001;
      if (avs_write || stop_seen || arb_lost) nph <= 2'h0;
      else if (scl_oe != prev && nph != 2'h3) nph <= nph + 2'h1;
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  sequence s_rd_answer;
    avs_waitrequest ##1 !avs_waitrequest;
  endsequence
  property p_rd_wait; $rose(avs_read) |-> s_rd_answer; endproperty
  property p_wr_nowait; avs_write |-> !avs_waitrequest; endproperty
  property p_unmapped; $rose(avs_read) && !mapped |=> avs_readdata == 32'h0; endproperty
  property p_rsv; $rose(avs_read) && avs_address == 8'h18 |=> avs_readdata[31:16] == 16'h0 && !avs_readdata[3];
  endproperty
  property p_scl_out; scl_out == 1'b0; endproperty
  property p_start_set; $rose(start_sent_flag) |-> $past(start_req); endproperty
  property p_start_clr; addr_done && !start_req |=> !start_sent_flag; endproperty
  property p_low; $fell(scl_oe) && nph >= 2'h2 |-> cnt == lo; endproperty
  property p_high; $rose(scl_oe) && nph >= 2'h2 |-> cnt == hi; endproperty
  a_rd_wait: assert property (p_rd_wait) else $error("read answer not after one wait");
  a_wr_nowait: assert property (p_wr_nowait) else $error("write was held off");
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  a_rsv: assert property (p_rsv) else $error("status reserved bits set");
  a_scl_out: assert property (p_scl_out) else $error("SCL drive level not low");
  a_start_set: assert property (p_start_set) else $error("start flag rose without request");
  a_start_clr: assert property (p_start_clr) else $error("start flag kept after address");
  a_low: assert property (p_low) else $error("SCL low phase length wrong");
  a_high: assert property (p_high) else $error("SCL high phase length wrong");
endmodule
bind i2csc_status_clk i2csc_port_checker #(.DIV_W(DIV_W)) u_chk (.*);

// ==== test/i2csc_status_clk_bench.sv ====
`timescale 1ns/10ps
// ****
// Bench
// ****
module i2csc_status_clk_bench;
  reg clk_sys = 1'b0, reset_n = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
  reg [7:0] avs_address = 8'h00;
  reg [31:0] avs_writedata = 32'h0, rd;
  reg [3:0] avs_byteenable = 4'h3;
  wire [31:0] avs_readdata;
  wire avs_waitrequest, sda_in, scl_in, scl_out, scl_oe, start_sent_flag;
  reg start_req = 1'b0, addr_done = 1'b0, addr_rw = 1'b0, slave_addressed = 1'b0;
  reg arb_lost = 1'b0, restart_seen = 1'b0, stop_seen = 1'b0, pull_sda = 1'b0, pull_scl = 1'b0;
  reg [6:0] addr_rx = 7'h00;
  int mismatches = 0, compares = 0, n;
  logic [31:0] srow [0:7] = '{32'h1D220414, 32'h1D338002, 32'h1D084000, 32'h19080004,
    32'h1D612412, 32'h15610004, 32'h1D001000, 32'h0D000004};
  logic [19:0] mrow [0:2] = '{20'h00041, 20'h80034, 20'hC0010};
  i2csc_status_clk #(.DIV_W(12)) dut (.*);
  i2csc_bus_model u_bus (.*);
  // 10 MHz clock, an integer multiple of 10 MHz
  always #50 clk_sys = ~clk_sys;
  task chk(input string nm, input [15:0] e, input [15:0] g);
    compares = compares + 1;
    if (g !== e) begin
      mismatches = mismatches + 1;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task wr(input [7:0] a, input [15:0] d);
    avs_address <= a;
    avs_writedata <= {16'h0000, d};
    avs_write <= 1'b1;
    do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
    avs_write <= 1'b0;
    @(posedge clk_sys);
  endtask
  task rdc(input [7:0] a, input [15:0] m, input [15:0] e, input string nm);
    avs_address <= a;
    avs_read <= 1'b1;
    do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_read <= 1'b0;
    @(posedge clk_sys);
    chk(nm, e, rd[15:0] & m);
  endtask
  // Event pulses: stop, restart, arbitration lost
  task pl(input [2:0] v);
    {stop_seen, restart_seen, arb_lost} <= v;
    @(posedge clk_sys);
    {stop_seen, restart_seen, arb_lost} <= 3'h0;
    @(posedge clk_sys);
  endtask
  task adr(input [6:0] a, input rw, input sl);
    {addr_rx, addr_rw, slave_addressed, addr_done} <= {a, rw, sl, 1'b1};
    @(posedge clk_sys);
    addr_done <= 1'b0;
    @(posedge clk_sys);
  endtask
  task clr(input [3:0] k);
    if (k != 4'h0) pl(k[2:0]);
    else wr(8'h00, 16'h0000);
  endtask
  task t_reset;
    rdc(8'h18, 16'hFFFF, 16'h0002, "status");
    rdc(8'h1C, 16'hFFFF, 16'h0000, "clkcfg");
    rdc(8'h40, 16'hFFFF, 16'h0000, "unmapped");
    pl(3'h4);
    wr(8'h18, 16'hFFFF);
    rdc(8'h18, 16'hFFFF, 16'h0000, "status ro");
    pull_sda <= 1'b1;
    repeat (4) @(posedge clk_sys);
    rdc(8'h18, 16'h0002, 16'h0002, "busy sda");
    {pull_sda, pull_scl} <= 2'h1;
    pl(3'h4);
    rdc(8'h18, 16'h0002, 16'h0002, "busy scl");
    pull_scl <= 1'b0;
    repeat (4) @(posedge clk_sys);
    pl(3'h4);
    rdc(8'h18, 16'h0002, 16'h0000, "busy stop");
    $display("t_reset done");
  endtask
  task t_cfg;
    wr(8'h1C, 16'hF123);
    rdc(8'h1C, 16'hFFFF, 16'hC123, "clkcfg");
    wr(8'h00, 16'h0001);
    wr(8'h1C, 16'h0004);
    rdc(8'h1C, 16'hFFFF, 16'hC123, "clkcfg locked");
    wr(8'h00, 16'h0003);
    wr(8'h08, 16'h005A);
    rdc(8'h18, 16'hFF00, 16'h5A00, "pec");
    wr(8'h00, 16'h0000);
    $display("t_cfg done");
  endtask
  task t_slave;
    wr(8'h04, 16'h3322);
    for (int i = 0; i < 8; i++) begin
      wr(8'h00, {8'h00, srow[i][31:24]});
      adr(srow[i][22:16], srow[i][4], 1'b1);
      rdc(8'h18, 16'h00FF, {8'h00, srow[i][15:8]}, "slave flags");
      clr(srow[i][3:0]);
      rdc(8'h18, 16'h00F4, 16'h0000, "slave clear");
    end
    $display("t_slave done");
  endtask
  task t_master;
    for (int i = 0; i < 3; i++) begin
      wr(8'h00, 16'h0000);
      pl(3'h4);
      wr(8'h1C, mrow[i][19:4]);
      wr(8'h00, 16'h0001);
      start_req <= 1'b1;
      n = 0;
      while (start_sent_flag !== 1'b1 && n < 50) begin
        @(posedge clk_sys);
        n++;
      end
      chk("start set", 16'h0001, {15'h0, start_sent_flag});
      start_req <= 1'b0;
      adr(7'h50, 1'b0, 1'b0);
      chk("start clear", 16'h0000, {15'h0, start_sent_flag});
      repeat (200) @(posedge clk_sys);
      rdc(8'h18, 16'h0005, 16'h0005, "master");
      clr(mrow[i][3:0]);
      rdc(8'h18, 16'h0005, 16'h0000, "master end");
    end
    $display("t_master done");
  endtask
  task summarize;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (5) @(posedge clk_sys);
    reset_n <= 1'b1;
    @(posedge clk_sys);
    t_reset;
    t_cfg;
    t_slave;
    t_master;
    summarize;
  end
  // Watchdog
  initial begin
    repeat (20000) @(posedge clk_sys);
    mismatches = mismatches + 1;
    summarize;
  end
endmodule
